/* fan_tach_and_drive.v */
// fan tachometer timing and four channel pwm or dc fan drive with banked registers
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "fan_defs.vh"
// Summary of operation
// - fan counts read-only at bank0 28h 29h 2Ah 3Fh and bank5 53h
// - count is ticks between divided tach pulses; rpm = 1.35e6*divisor/count
// - three-bit divisor code selects division by two to the code
// - divisors reset to two; fields spread over 47h 4Bh 4Ch 59h 5Dh
// - four outputs, pwm or dc chosen by 04h bits 1-0, 12h bit 0, 62h bit 6
// - pwm duty is output value over 255; values at 01h 03h 11h 61h
// - output values reset to FFh, full duty
// - each pwm rate set by its frequency register 00h 02h 10h 60h
// - dc level is six-bit code from output value, 3.3 V times code/64
// - dc code resets to all ones; two low bits ignored
// - automatic control starts from the held output value
// - system output uses system temperature; others selected by 49h and 4Ah
module fan_tach_and_drive #(
   parameter TICK_CYC = `CLK_HZ / `TACH_TICK_HZ
) (
   input wire clk,
   input wire arst_n,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire [4:0] tach_in,
   input wire [3:0] auto_en,
   input wire [3:0] auto_wr,
   input wire [31:0] auto_data,
   output wire [3:0] fan_pwm,
   output wire [23:0] fan_dac,
   output wire [3:0] fan_is_dc,
   output wire [11:0] temp_src
);

   // configuration registers
   reg [7:0] freq_r [0:3];
   reg [7:0] val_r [0:3];
   reg [7:0] type_a_r;
   reg [7:0] type_b_r;
   reg [7:0] type_c_r;
   reg [7:0] src_a_r;
   reg [7:0] src_b_r;
   reg [7:0] div_a_r;
   reg [7:0] div_b_r;
   reg [7:0] div_c_r;
   reg [7:0] div_d_r;
   reg [7:0] div_e_r;
   reg [2:0] bank_r;
   wire [7:0] count [0:4];
   wire [2:0] div_code [0:4];
   wire [3:0] dc_mode;
   reg [7:0] rdata_nxt;
   wire bank0;
   wire wr0;
   integer k;
   integer m;

   assign bank0 = (bank_r == `BANK_0);
   assign wr0 = reg_wr & bank0;

   // divisor fields assembled from the scattered register bits
   assign div_code[0] = {div_e_r[5], div_a_r[5:4]};
   assign div_code[1] = {div_e_r[6], div_a_r[7:6]};
   assign div_code[2] = {div_e_r[7], div_b_r[7:6]};
   assign div_code[3] = {div_d_r[7], div_d_r[3:2]};
   assign div_code[4] = {div_c_r[7], div_c_r[6:5]};

   // output type bits, high selects dc
   assign dc_mode = {type_c_r[6], type_b_r[0], type_a_r[1], type_a_r[0]};
   assign fan_is_dc = dc_mode;

   // temperature source pairing for automatic control
   assign temp_src[2:0] = `SRC_SYSTEM_TEMP;
   assign temp_src[5:3] = src_a_r[2:0];
   assign temp_src[8:6] = src_a_r[6:4];
   assign temp_src[11:9] = src_b_r[7:5];

   // bank select answers in every bank, so software can always get back to bank 0
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bank_r <= `BANK_0;
      end else if (reg_wr && reg_addr == `IDX_BANK) begin
         bank_r <= reg_wdata[2:0];
      end
   end

   // pwm frequency registers, one per output
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (k = 0; k < 4; k = k + 1) begin
            freq_r[k] <= `RST_FREQ;
         end
      end else if (wr0) begin
         case (reg_addr)
            `IDX_SYS_FREQ: freq_r[0] <= reg_wdata;
            `IDX_CPU0_FREQ: freq_r[1] <= reg_wdata;
            `IDX_AUX_FREQ: freq_r[2] <= reg_wdata;
            `IDX_CPU1_FREQ: freq_r[3] <= reg_wdata;
            default: ;
         endcase
      end
   end

   // output values; software write wins over an automatic update in the same cycle
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (m = 0; m < 4; m = m + 1) begin
            val_r[m] <= `RST_VAL;
         end
      end else begin
         // the controller only ever modifies the held value, never reloads it
         for (m = 0; m < 4; m = m + 1) begin
            if (auto_en[m] && auto_wr[m]) begin
               val_r[m] <= auto_data[m*8 +: 8];
            end
         end
         if (wr0) begin
            case (reg_addr)
               `IDX_SYS_VAL: val_r[0] <= reg_wdata;
               `IDX_CPU0_VAL: val_r[1] <= reg_wdata;
               `IDX_AUX_VAL: val_r[2] <= reg_wdata;
               `IDX_CPU1_VAL: val_r[3] <= reg_wdata;
               default: ;
            endcase
         end
      end
   end

   // output type selects, pwm after reset
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         type_a_r <= `RST_TYPE;
         type_b_r <= `RST_TYPE;
         type_c_r <= `RST_TYPE;
      end else if (wr0) begin
         case (reg_addr)
            `IDX_TYPE_A: type_a_r <= reg_wdata;
            `IDX_TYPE_B: type_b_r <= reg_wdata;
            `IDX_TYPE_C: type_c_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   // temperature source selects; only the fields listed above are used
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         src_a_r <= `RST_SRC;
         src_b_r <= `RST_SRC;
      end else if (wr0) begin
         case (reg_addr)
            `IDX_SRC_A: src_a_r <= reg_wdata;
            `IDX_SRC_B: src_b_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   // divisor registers; whole bytes kept so unrelated bits read back as written
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_a_r <= `RST_DIV_A;
         div_b_r <= `RST_DIV_B;
         div_c_r <= `RST_DIV_C;
         div_d_r <= `RST_DIV_D;
         div_e_r <= `RST_DIV_E;
      end else if (wr0) begin
         case (reg_addr)
            `IDX_DIV_A: div_a_r <= reg_wdata;
            `IDX_DIV_B: div_b_r <= reg_wdata;
            `IDX_DIV_C: div_c_r <= reg_wdata;
            `IDX_DIV_D: div_d_r <= reg_wdata;
            `IDX_DIV_E: div_e_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   // read mux; unmapped or wrong-bank indices read zero
   always @* begin
      rdata_nxt = 8'h00;
      if (reg_addr == `IDX_BANK) begin
         rdata_nxt = {5'h00, bank_r};
      end else if (bank_r == `BANK_5) begin
         if (reg_addr == `IDX_COUNT_E) begin
            rdata_nxt = count[4];
         end
      end else if (bank0) begin
         case (reg_addr)
            `IDX_SYS_FREQ: rdata_nxt = freq_r[0];
            `IDX_SYS_VAL: rdata_nxt = val_r[0];
            `IDX_CPU0_FREQ: rdata_nxt = freq_r[1];
            `IDX_CPU0_VAL: rdata_nxt = val_r[1];
            `IDX_AUX_FREQ: rdata_nxt = freq_r[2];
            `IDX_AUX_VAL: rdata_nxt = val_r[2];
            `IDX_CPU1_FREQ: rdata_nxt = freq_r[3];
            `IDX_CPU1_VAL: rdata_nxt = val_r[3];
            `IDX_TYPE_A: rdata_nxt = type_a_r;
            `IDX_TYPE_B: rdata_nxt = type_b_r;
            `IDX_TYPE_C: rdata_nxt = type_c_r;
            `IDX_SRC_A: rdata_nxt = src_a_r;
            `IDX_SRC_B: rdata_nxt = src_b_r;
            `IDX_DIV_A: rdata_nxt = div_a_r;
            `IDX_DIV_B: rdata_nxt = div_b_r;
            `IDX_DIV_C: rdata_nxt = div_c_r;
            `IDX_DIV_D: rdata_nxt = div_d_r;
            `IDX_DIV_E: rdata_nxt = div_e_r;
            `IDX_COUNT_A: rdata_nxt = count[0];
            `IDX_COUNT_B: rdata_nxt = count[1];
            `IDX_COUNT_C: rdata_nxt = count[2];
            `IDX_COUNT_D: rdata_nxt = count[3];
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   // read data valid only in the cycle after the strobe
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_nxt;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // shared count tick, so all channels measure against one time base
   reg [15:0] tick_cnt_r;
   reg tick_r;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tick_cnt_r <= 16'h0000;
         tick_r <= 1'b0;
      end else if (tick_cnt_r == TICK_CYC[15:0] - 16'h0001) begin
         tick_cnt_r <= 16'h0000;
         tick_r <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 16'h0001;
         tick_r <= 1'b0;
      end
   end

   genvar g;

   // tachometer channels
   generate
      for (g = 0; g < 5; g = g + 1) begin : tach
         reg prev_r;
         reg [6:0] edge_cnt_r;
         reg [7:0] time_r;
         reg [7:0] count_r;
         wire rise;
         wire [7:0] edges_needed;
         assign rise = tach_in[g] & ~prev_r;
         assign edges_needed = 8'h01 << div_code[g];
         assign count[g] = count_r;
         // count ticks over 2^code rising edges, then latch the result
         always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               prev_r <= 1'b0;
               edge_cnt_r <= 7'h00;
               time_r <= 8'h00;
               count_r <= `RST_COUNT;
            end else begin
               prev_r <= tach_in[g];
               if (rise && ({1'b0, edge_cnt_r} + 8'h01 == edges_needed)) begin
                  count_r <= time_r;
                  time_r <= 8'h00;
                  edge_cnt_r <= 7'h00;
               end else begin
                  if (rise) begin
                     edge_cnt_r <= edge_cnt_r + 7'h01;
                  end
                  if (time_r == `COUNT_MAX) begin
                     count_r <= `COUNT_MAX;
                  end else if (tick_r) begin
                     time_r <= time_r + 8'h01;
                  end
               end
            end
         end
      end
   endgenerate

   // fan drive channels
   generate
      for (g = 0; g < 4; g = g + 1) begin : drive
         reg [7:0] pre_r;
         reg [7:0] pos_r;
         reg [7:0] duty_r;
         reg pwm_r;
         reg [5:0] dac_r;
         assign fan_pwm[g] = pwm_r;
         assign fan_dac[g*6 +: 6] = dac_r;
         // step prescaler from the frequency register, 255 steps per period
         always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               pre_r <= 8'h00;
               pos_r <= 8'h00;
               duty_r <= `RST_VAL;
               pwm_r <= 1'b1;
               dac_r <= `RST_DAC;
            end else begin
               if (pre_r >= freq_r[g]) begin
                  pre_r <= 8'h00;
                  if (pos_r == `PWM_LAST) begin
                     pos_r <= 8'h00;
                     duty_r <= val_r[g];
                  end else begin
                     pos_r <= pos_r + 8'h01;
                  end
               end else begin
                  pre_r <= pre_r + 8'h01;
               end
               // ffh never compares below, so full duty is a solid high
               pwm_r <= ~dc_mode[g] & (pos_r < duty_r);
               // dc level follows at once; low two bits are don't-care
               dac_r <= dc_mode[g] ? val_r[g][7:2] : 6'h00;
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

/* fan_defs.vh */
// constants for the fan speed measurement and fan drive block
`ifndef FAN_DEFS_VH
`define FAN_DEFS_VH

// clock and tachometer count rate
`define CLK_HZ 25000000
`define TACH_TICK_HZ 22500

// register indices, bank 0 except 4Eh (every bank) and 53h (bank 5)
`define IDX_SYS_FREQ 8'h00
`define IDX_SYS_VAL 8'h01
`define IDX_CPU0_FREQ 8'h02
`define IDX_CPU0_VAL 8'h03
`define IDX_TYPE_A 8'h04
`define IDX_AUX_FREQ 8'h10
`define IDX_AUX_VAL 8'h11
`define IDX_TYPE_B 8'h12
`define IDX_COUNT_A 8'h28
`define IDX_COUNT_B 8'h29
`define IDX_COUNT_C 8'h2a
`define IDX_COUNT_D 8'h3f
`define IDX_DIV_A 8'h47
`define IDX_SRC_A 8'h49
`define IDX_SRC_B 8'h4a
`define IDX_DIV_B 8'h4b
`define IDX_DIV_C 8'h4c
`define IDX_BANK 8'h4e
`define IDX_COUNT_E 8'h53
`define IDX_DIV_D 8'h59
`define IDX_DIV_E 8'h5d
`define IDX_CPU1_FREQ 8'h60
`define IDX_CPU1_VAL 8'h61
`define IDX_TYPE_C 8'h62

// bank codes
`define BANK_0 3'h0
`define BANK_5 3'h5

// reset values; each divisor field resets to code 001 (divide by 2)
`define RST_VAL 8'hff
`define RST_FREQ 8'h04
`define RST_TYPE 8'h00
`define RST_SRC 8'h00
`define RST_DIV_A 8'h50
`define RST_DIV_B 8'h40
`define RST_DIV_C 8'h20
`define RST_DIV_D 8'h04
`define RST_DIV_E 8'h00
`define RST_COUNT 8'hff
`define RST_DAC 6'h3f

// pwm step layout: 255 steps per period, positions 0 to 254
`define PWM_LAST 8'hfe
`define COUNT_MAX 8'hff

// fixed temperature source code of the system fan output
`define SRC_SYSTEM_TEMP 3'h0

`endif

/* fan_tach_and_drive_monitor.sv */
// assertion checker for the fan tach and drive block
`timescale 1ns/1ps
`default_nettype none
module fan_tach_and_drive_monitor (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [4:0] tach_in,
   input wire logic [3:0] auto_en,
   input wire logic [3:0] auto_wr,
   input wire logic [31:0] auto_data,
   input wire logic [3:0] fan_pwm,
   input wire logic [23:0] fan_dac,
   input wire logic [3:0] fan_is_dc,
   input wire logic [11:0] temp_src
);
   logic [5:0] dc_exp_r;
   logic [2:0] bank_seen_r;
   // bank select as seen on the bus; bank 0 registers ignore writes in other banks
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         bank_seen_r <= 3'h0;
      else if (reg_wr && reg_addr == 8'h4e)
         bank_seen_r <= reg_wdata[2:0];
   end
   // expected dc code of the system output
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         dc_exp_r <= 6'h3f;
      else if (reg_wr && reg_addr == 8'h01 && bank_seen_r == 3'h0)
         dc_exp_r <= reg_wdata[7:2];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its slot");
   a_sys_temp: assert property (temp_src[2:0] == 3'h0)
      else $error("system output source not fixed");
   a_src_pair_a: assert property (reg_wr && reg_addr == 8'h49 && bank_seen_r == 3'h0 |=>
      temp_src[5:3] == $past(reg_wdata[2:0]) && temp_src[8:6] == $past(reg_wdata[6:4]))
      else $error("source select a wrong");
   a_src_pair_b: assert property (reg_wr && reg_addr == 8'h4a && bank_seen_r == 3'h0 |=> temp_src[11:9] == $past(reg_wdata[7:5]))
      else $error("source select b wrong");
   a_type_low: assert property (reg_wr && reg_addr == 8'h04 && bank_seen_r == 3'h0 |=> fan_is_dc[1:0] == $past(reg_wdata[1:0]))
      else $error("output type a wrong");
   a_type_high: assert property (reg_wr && reg_addr == 8'h62 && bank_seen_r == 3'h0 |=> fan_is_dc[3] == $past(reg_wdata[6]))
      else $error("output type c wrong");
   a_dc_pwm_low: assert property (fan_is_dc[0] && $past(fan_is_dc[0]) |-> !fan_pwm[0])
      else $error("pwm active in dc mode");
   a_dc_level: assert property (reg_wr && reg_addr == 8'h01 && bank_seen_r == 3'h0 && fan_is_dc[0] |-> ##[1:2] fan_dac[5:0] == dc_exp_r)
      else $error("dc code not applied");
   c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
   c_src: cover property (reg_wr && reg_addr == 8'h49);
   c_dc: cover property (fan_is_dc[0] && reg_wr && reg_addr == 8'h01);
endmodule
bind fan_tach_and_drive fan_tach_and_drive_monitor mon (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tach_in(tach_in),
   .auto_en(auto_en), .auto_wr(auto_wr), .auto_data(auto_data), .fan_pwm(fan_pwm), .fan_dac(fan_dac),
   .fan_is_dc(fan_is_dc), .temp_src(temp_src));
`default_nettype wire

/* fan_tach_model.sv */
// five fans with tachometer outputs pulsing at a common period
`timescale 1ns/1ps
`default_nettype none
module fan_tach_model (
   input wire logic clk,
   input wire logic [15:0] period,
   output logic [4:0] tach
);
   logic [15:0] cnt_r = 16'h0000;
   initial tach = 5'h00;
   // high for the first half of each period; zero period is a stalled rotor, line stays low
   always @(posedge clk) begin
      cnt_r <= (cnt_r + 16'h0001 >= period) ? 16'h0000 : cnt_r + 16'h0001;
      tach <= {5{period != 16'h0000 && cnt_r < period / 2}};
   end
endmodule
`default_nettype wire

/* fan_tach_and_drive_tb.sv */
// self-checking bench for the fan tach and drive block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module fan_tach_and_drive_tb;
   typedef struct {logic wr; logic [7:0] addr; logic [7:0] data; logic [7:0] exp;} row_t;
   logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd;
   logic [4:0] tach_in;
   logic [3:0] auto_en = 4'h0, auto_wr = 4'h0, fan_pwm, fan_is_dc;
   logic [31:0] auto_data = 32'h0;
   logic [23:0] fan_dac;
   logic [11:0] temp_src;
   logic [15:0] period = 16'd40;
   logic [9:0] hi;
   int miscompares = 0, comparisons = 0, cycles = 0;
   row_t rows[12] = '{'{0, 8'h01, 0, 8'hff}, '{0, 8'h03, 0, 8'hff}, '{0, 8'h11, 0, 8'hff}, '{0, 8'h61, 0, 8'hff},
      '{0, 8'h47, 0, 8'h50}, '{0, 8'h4b, 0, 8'h40}, '{0, 8'h4c, 0, 8'h20}, '{0, 8'h59, 0, 8'h04},
      '{0, 8'h5d, 0, 8'h00}, '{1, 8'h01, 8'h80, 8'h80}, '{1, 8'h20, 8'h55, 8'h00}, '{1, 8'h61, 8'h3c, 8'h3c}};
   logic [7:0] d47[3] = '{8'h40, 8'h70, 8'h40}, d5d[3] = '{8'h00, 8'h00, 8'h20};
   int ex[3] = '{10, 80, 160};
   fan_tach_model fans (.clk(clk), .period(period), .tach(tach_in));
   // tick of 4 clocks keeps the count window short
   fan_tach_and_drive #(.TICK_CYC(4)) uut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tach_in(tach_in), .auto_en(auto_en),
      .auto_wr(auto_wr), .auto_data(auto_data), .fan_pwm(fan_pwm), .fan_dac(fan_dac), .fan_is_dc(fan_is_dc),
      .temp_src(temp_src));
   always #20 clk = ~clk;
   // hang guard, well above the few thousand cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         finish_test();
      end
   end
   task automatic finish_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // bus cycles start off the edge, so nothing races the sampling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic rdr(input logic [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
      @(posedge clk);
      #1;
   endtask
   task automatic cnt_chk(input logic [7:0] a, input int e);
      rdr(a);
      `CHK(rd >= e - 1 && rd <= e + 1, 1'b1)
   endtask
   task automatic pwm_hi(input int n);
      hi = 10'h000;
      repeat (n) begin
         @(posedge clk);
         #1 hi += {9'h000, fan_pwm[0]};
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      #1 arst_n = 1'b1;
      pwm_hi(255);
      `CHK(hi, 10'd255)
      for (int i = 0; i < 12; i++) begin
         if (rows[i].wr)
            wr(rows[i].addr, rows[i].data);
         rdr(rows[i].addr);
         `CHK(rd, rows[i].exp)
      end
      $display("register rows done");
      cnt_chk(8'h29, 20);
      for (int i = 0; i < 3; i++) begin
         wr(8'h47, d47[i]);
         wr(8'h5d, d5d[i]);
         repeat (ex[i] * 8 + 50) @(posedge clk);
         cnt_chk(8'h28, ex[i]);
      end
      wr(8'h5d, 8'h00);
      wr(8'h47, 8'h50);
      wr(8'h4e, 8'h05);
      cnt_chk(8'h53, 20);
      rdr(8'h01);
      `CHK(rd, 8'h00)
      wr(8'h4e, 8'h00);
      period <= 16'd0;
      repeat (1200) @(posedge clk);
      wr(8'h28, 8'h00);
      rdr(8'h28);
      `CHK(rd, 8'hff)
      period <= 16'd40;
      $display("tach tests done");
      wr(8'h04, 8'h03);
      `CHK(fan_dac[11:6], 6'h3f)
      wr(8'h03, 8'ha7);
      wr(8'h01, 8'hc4);
      `CHK({fan_dac[11:0], fan_pwm[1:0]}, {6'h29, 6'h31, 2'b00})
      wr(8'h12, 8'h01);
      wr(8'h62, 8'h40);
      `CHK(fan_is_dc, 4'hf)
      wr(8'h04, 8'h00);
      wr(8'h12, 8'h00);
      wr(8'h62, 8'h00);
      $display("dc tests done");
      wr(8'h00, 8'h00);
      wr(8'h01, 8'h40);
      repeat (600) @(posedge clk);
      pwm_hi(255);
      `CHK(hi, 10'd64)
      wr(8'h00, 8'h01);
      repeat (1100) @(posedge clk);
      pwm_hi(510);
      `CHK(hi, 10'd128)
      @(posedge fan_pwm[0]);
      wr(8'h01, 8'h00);
      repeat (20) @(posedge clk);
      #1 `CHK(fan_pwm[0], 1'b1)
      repeat (600) @(posedge clk);
      #1 `CHK(fan_pwm[0], 1'b0)
      $display("pwm tests done");
      wr(8'h11, 8'h33);
      auto_en <= 4'h4;
      repeat (3) @(posedge clk);
      rdr(8'h11);
      `CHK(rd, 8'h33)
      auto_data <= 32'h00550000;
      auto_wr <= 4'h4;
      @(posedge clk);
      #1 auto_wr <= 4'h0;
      rdr(8'h11);
      `CHK(rd, 8'h55)
      wr(8'h49, 8'h52);
      wr(8'h4a, 8'ha0);
      `CHK(temp_src, 12'hb50)
      arst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 arst_n = 1'b1;
      rdr(8'h11);
      `CHK(rd, 8'hff)
      $display("auto and reset tests done");
      finish_test();
   end
endmodule
`default_nettype wire
